// ===== design/pssr_host.sv
// Decided for this implementation: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module pssr_host #(
  parameter int WAIT_CYC = pssr_pkg::WAIT_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [pssr_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [pssr_pkg::DW-1:0] avs_writedata,
  output logic [pssr_pkg::DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  pssr_if.host link
);
  import pssr_pkg::*;
  localparam int CW = ($clog2(WAIT_CYC + 1) > 7) ? $clog2(WAIT_CYC + 1) : 7;
  typedef struct packed {
    pssr_host_st_t st;
    logic [1:0] step;
    logic [1:0] mode;
    logic [CW-1:0] cnt;
    logic [2:0] bitn;
    logic [1:0] byten;
    logic [7:0] sh_tx;
    logic [7:0] sh_rx;
    logic sclk;
    logic ss_n;
    logic mosi;
    logic [7:0] stat;
    logic [23:0] press;
    logic [1:0] irq_st;
    logic [1:0] irq_mask;
    logic irq;
    logic wreq;
    logic [DW-1:0] rdata;
  } pssr_host_t;
  pssr_host_t q;
  pssr_host_t d;
  logic miso_s;
  logic eoc_s;
  logic [7:0] rx_byte;
  logic [1:0] ev;
  logic launch;
  logic [1:0] nstep;
  logic [1:0] last;
  logic [DW-1:0] r;

  function automatic logic [7:0] tx_byte(input logic [1:0] step,
                                         input logic [1:0] idx);
    logic [7:0] b;
    b = CMD_ARG;
    if (step == STEP_POLL)
    begin
      b = CMD_NOP;
    end
    else if (idx == 2'h0)
    begin
      b = (step == STEP_CMD) ? CMD_MEASURE : CMD_NOP;
    end
    return b;
  endfunction

  pssr_sync #(.W(2), .INIT(2'h0)) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ce(ce),
    .d_in({link.miso, link.eoc}),
    .q_out({miso_s, eoc_s})
  );

  always_comb
  begin
    d = q;
    ev = 2'h0;
    launch = 1'b0;
    nstep = STEP_CMD;
    r = '0;
    rx_byte = {q.sh_rx[6:0], miso_s};
    last = (q.step == STEP_CMD) ? CMD_LAST :
           (q.step == STEP_POLL) ? POLL_LAST : FETCH_LAST;
    // Avalon slave: one wait cycle, then data with waitrequest low
    if (!q.wreq)
    begin
      d.wreq = 1'b1;
      // Writes commit at the edge that completes the transfer
      if (avs_write && avs_address == REG_CTRL)
      begin
        d.mode = avs_writedata[CTRL_MODE +: 2];
        if (avs_writedata[CTRL_GO] && q.st == H_IDLE)
        begin
          launch = 1'b1;
        end
      end
      if (avs_write && avs_address == REG_MASK)
      begin
        d.irq_mask = avs_writedata[1:0];
      end
    end
    else if (avs_read || avs_write)
    begin
      d.wreq = 1'b0;
      case (avs_address)
        REG_CTRL:
        begin
          r[CTRL_GO] = (q.st != H_IDLE);
          r[CTRL_MODE +: 2] = q.mode;
        end
        REG_STAT:
        begin
          r[STAT_BUSY] = (q.st != H_IDLE);
          r[STAT_BYTE +: 8] = q.stat;
          r[STAT_ADDR +: 7] = TWI_ADDR;
        end
        REG_DATA: r[23:0] = q.press;
        REG_IRQ:
        begin
          r[1:0] = q.irq_st;
          if (avs_read)
          begin
            d.irq_st = 2'h0;
          end
        end
        REG_MASK:
        begin
          r[1:0] = q.irq_mask;
        end
        default: r = '0;
      endcase
      d.rdata = avs_read ? r : '0;
    end
    case (q.st)
      H_IDLE: d.sclk = 1'b0;
      H_LEAD, H_LOW:
      begin
        if (q.cnt != '0)
        begin
          d.cnt = q.cnt - 1'b1;
        end
        else
        begin
          d.sclk = 1'b1;
          d.st = H_HIGH;
          d.cnt = CW'(HALF_CYC - 1);
        end
      end
      H_HIGH:
      begin
        if (q.cnt != '0)
        begin
          d.cnt = q.cnt - 1'b1;
        end
        else
        begin
          d.sclk = 1'b0;
          d.sh_rx = rx_byte;
          d.st = H_LOW;
          d.cnt = CW'(HALF_CYC - 1);
          if (q.bitn != 3'h7)
          begin
            d.bitn = q.bitn + 3'h1;
            d.sh_tx = {q.sh_tx[6:0], 1'b0};
            d.mosi = q.sh_tx[6];
          end
          else
          begin
            d.bitn = 3'h0;
            // Bytes of the measure frame are dropped
            if (q.step == STEP_POLL)
            begin
              d.stat = rx_byte;
            end
            else if (q.step == STEP_FETCH)
            begin
              if (q.byten == 2'h0)
              begin
                d.stat = rx_byte;
              end
              else
              begin
                d.press = {q.press[15:0], rx_byte};
              end
            end
            if (q.byten == last)
            begin
              d.st = H_TRAIL;
              d.mosi = 1'b0;
              d.cnt = CW'(SUSS_CYC - 1);
            end
            else
            begin
              d.byten = q.byten + 2'h1;
              d.sh_tx = tx_byte(q.step, q.byten + 2'h1);
              d.mosi = d.sh_tx[7];
            end
          end
        end
      end
      H_TRAIL:
      begin
        if (q.cnt != '0)
        begin
          d.cnt = q.cnt - 1'b1;
        end
        else
        begin
          d.ss_n = 1'b1;
          d.st = H_GAP;
          d.cnt = CW'(BUS_CYC - 1);
        end
      end
      H_GAP:
      begin
        if (q.cnt != '0)
        begin
          d.cnt = q.cnt - 1'b1;
        end
        else if (q.step == STEP_CMD)
        begin
          if (q.mode == WAIT_POLL)
          begin
            launch = 1'b1;
            nstep = STEP_POLL;
          end
          else
          begin
            d.st = H_WAIT;
            d.cnt = CW'(WAIT_CYC - 1);
          end
        end
        else if (q.step == STEP_POLL)
        begin
          launch = 1'b1;
          nstep = q.stat[ST_BUSY] ? STEP_POLL : STEP_FETCH;
        end
        else
        begin
          d.st = H_IDLE;
          ev[IRQ_DONE] = 1'b1;
          ev[IRQ_ERR] = q.stat[ST_MEMF] | q.stat[ST_SAT];
        end
      end
      H_WAIT:
      begin
        if (q.mode == WAIT_DELAY)
        begin
          if (q.cnt != '0)
          begin
            d.cnt = q.cnt - 1'b1;
          end
          else
          begin
            launch = 1'b1;
            nstep = STEP_FETCH;
          end
        end
        else if (eoc_s)
        begin
          launch = 1'b1;
          nstep = STEP_FETCH;
        end
      end
      default: d.st = H_IDLE;
    endcase
    if (launch)
    begin
      d.st = H_LEAD;
      d.step = nstep;
      d.ss_n = 1'b0;
      d.sclk = 1'b0;
      d.bitn = 3'h0;
      d.byten = 2'h0;
      d.sh_tx = tx_byte(nstep, 2'h0);
      d.mosi = d.sh_tx[7];
      d.cnt = CW'(HDSS_CYC - 1);
    end
    d.irq_st = d.irq_st | ev;
    d.irq = |(d.irq_st & d.irq_mask);
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '0;
      q.st <= H_IDLE;
      q.ss_n <= 1'b1;
      q.wreq <= 1'b1;
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  assign link.sclk = q.sclk;
  assign link.mosi = q.mosi;
  assign link.ss_n = q.ss_n;
  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.wreq;
  assign irq = q.irq;
endmodule
`default_nettype wire

// ===== design/pssr_sensor.sv
`timescale 1ns/1ns
`default_nettype none
module pssr_sensor #(
  parameter int CONV = pssr_pkg::CONV_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [23:0] pressure_sample,
  input wire logic math_sat,
  input wire logic mem_fail,
  output logic conv_busy,
  pssr_if.sensor link
);
  import pssr_pkg::*;
  localparam int CW = $clog2(CONV + 1);
  typedef struct packed {
    pssr_dev_st_t st;
    logic busy;
    logic eoc;
    logic [CW-1:0] cnt;
    logic sclk_p;
    logic ss_p;
    logic [2:0] bitn;
    logic [1:0] nrx;
    logic [7:0] rx;
    logic [7:0] cmd;
    logic [31:0] tx;
    logic miso;
    logic [23:0] press;
    logic sat;
    logic memf;
    logic memf_ok;
  } pssr_dev_t;
  pssr_dev_t q;
  pssr_dev_t d;
  logic sclk_s;
  logic mosi_s;
  logic ss_s;
  logic [7:0] status;
  logic [7:0] rx_byte;

  pssr_sync #(.W(3), .INIT(3'h4)) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ce(ce),
    .d_in({link.ss_n, link.sclk, link.mosi}),
    .q_out({ss_s, sclk_s, mosi_s})
  );

  always_comb
  begin
    d = q;
    status = 8'h00;
    status[ST_POWER] = 1'b1;
    status[ST_BUSY] = q.busy;
    status[ST_MEMF] = q.memf;
    status[ST_SAT] = q.sat;
    rx_byte = {q.rx[6:0], mosi_s};
    d.sclk_p = sclk_s;
    d.ss_p = ss_s;
    if (!q.memf_ok)
    begin
      d.memf = mem_fail;
      d.memf_ok = 1'b1;
    end
    if (q.ss_p && !ss_s)
    begin
      // Selection loads status then result, first bit before any edge
      d.tx = {status, q.press};
      d.miso = status[7];
      d.bitn = 3'h0;
      d.nrx = 2'h0;
      d.cmd = 8'h00;
    end
    else if (!ss_s)
    begin
      if (!q.sclk_p && sclk_s)
      begin
        d.rx = rx_byte;
        d.bitn = q.bitn + 3'h1;
        if (q.bitn == 3'h7)
        begin
          if (q.nrx == 2'h0)
          begin
            d.cmd = rx_byte;
          end
          if (q.nrx != MEAS_BYTES)
          begin
            d.nrx = q.nrx + 2'h1;
          end
        end
      end
      if (q.sclk_p && !sclk_s)
      begin
        // Full duplex: reply shifts out while command shifts in
        d.tx = {q.tx[30:0], 1'b0};
        d.miso = q.tx[30];
      end
    end
    case (q.st)
      D_STANDBY:
      begin
        // Only a complete measure frame starts; nop leaves it idle
        if (!q.ss_p && ss_s && q.cmd == CMD_MEASURE && q.nrx == MEAS_BYTES)
        begin
          d.st = D_CONVERT;
          d.busy = 1'b1;
          d.eoc = 1'b0;
          d.cnt = CW'(CONV - 1);
        end
      end
      D_CONVERT:
      begin
        // Commands arriving now are dropped
        if (q.cnt != '0)
        begin
          d.cnt = q.cnt - 1'b1;
        end
        else
        begin
          d.st = D_STANDBY;
          d.busy = 1'b0;
          d.eoc = 1'b1;
          d.press = pressure_sample;
          d.sat = math_sat;
        end
      end
      default:
      begin
        d.st = D_STANDBY;
        d.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '0;
      q.st <= D_STANDBY;
      q.ss_p <= 1'b1;
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  assign link.miso = q.miso;
  assign link.eoc = q.eoc;
  assign conv_busy = q.busy;
endmodule
`default_nettype wire

// ===== design/pssr_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pssr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pssr_sync_st_t;
  pssr_sync_st_t q;
  pssr_sync_st_t d;

  always_comb
  begin
    d = q;
    d.s1 = d_in;
    d.s2 = q.s1;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= {INIT, INIT};
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  assign q_out = q.s2;
endmodule
`default_nettype wire

// ===== dv/pressure_sensor_serial_readout_test.sv
`timescale 1ns/1ns
`default_nettype none
module pressure_sensor_serial_readout_test;
  import pssr_pkg::*;
  logic sys_clk;
  logic rst_b;
  logic [AW-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [DW-1:0] avs_writedata;
  logic [DW-1:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic [23:0] pressure;
  logic sat;
  logic mfail;
  logic busy_out;
  int miscompares;
  int checks_done;
  logic sclk_p;
  logic [5:0] nb;
  logic [31:0] mo;
  logic [31:0] mi;
  logic [5:0] fnb[$];
  logic [31:0] fmo[$];
  logic [31:0] fmi[$];
  logic [31:0] rd;

  pssr_if lk();
  pssr_host #(.WAIT_CYC(200)) i_pssr_host (.sys_clk(sys_clk), .rst_b(rst_b),
    .ce(1'b1), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .link(lk.host));
  pssr_sensor #(.CONV(100)) i_pssr_sensor (.sys_clk(sys_clk), .rst_b(rst_b),
    .ce(1'b1), .pressure_sample(pressure), .math_sat(sat), .mem_fail(mfail),
    .conv_busy(busy_out), .link(lk.sensor));
  pssr_properties #(.CONV(100)) i_pssr_properties (.sys_clk(sys_clk),
    .rst_b(rst_b), .sclk(lk.sclk), .mosi(lk.mosi), .ss_n(lk.ss_n),
    .miso(lk.miso), .eoc(lk.eoc));

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Records each frame's bits in both directions
  always @(posedge sys_clk)
  begin
    sclk_p <= lk.sclk;
    if (!lk.ss_n && lk.sclk && !sclk_p)
    begin
      mo <= {mo[30:0], lk.mosi};
      mi <= {mi[30:0], lk.miso};
      nb <= nb + 6'h01;
    end
    if (lk.ss_n && nb != 6'h00)
    begin
      fnb.push_back(nb);
      fmo.push_back(mo);
      fmi.push_back(mi);
      nb <= 6'h00;
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t exp %h got %h", $time, exp, got);
    end
  endtask

  task automatic acc(input logic w, input logic [AW-1:0] a,
    input logic [31:0] wd);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= wd;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0)
    begin
      n++;
      if (n > 50)
      begin
        miscompares++;
        summarize();
      end
      @(posedge sys_clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic reset();
    rst_b <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
  endtask

  task automatic run(input logic [1:0] mode, input logic [23:0] p,
    input logic s, input logic [1:0] msk);
    logic [7:0] st;
    logic er;
    int n;
    st = 8'h00;
    st[ST_POWER] = 1'b1;
    st[ST_MEMF] = mfail;
    st[ST_SAT] = s;
    er = mfail | s;
    n = 0;
    pressure <= p;
    sat <= s;
    acc(1'b1, REG_MASK, {30'h0, msk});
    fnb.delete();
    fmo.delete();
    fmi.delete();
    acc(1'b1, REG_CTRL, {29'h0, mode, 1'b1});
    acc(1'b0, REG_CTRL, 32'h0);
    cmp({29'h0, mode, 1'b1}, rd);
    while (rd[CTRL_GO] !== 1'b0)
    begin
      n++;
      if (n > 5000)
      begin
        miscompares++;
        summarize();
      end
      acc(1'b0, REG_CTRL, 32'h0);
    end
    repeat (4) @(posedge sys_clk);
    cmp({31'h0, msk[0] | (msk[1] & er)}, {31'h0, irq});
    acc(1'b0, REG_IRQ, 32'h0);
    cmp({30'h0, er, 1'b1}, rd);
    acc(1'b0, REG_IRQ, 32'h0);
    cmp(32'h0, rd);
    acc(1'b0, REG_DATA, 32'h0);
    cmp({8'h00, p}, rd & 32'h00FF_FFFF);
    cmp(32'h0, {31'h0, irq});
    acc(1'b0, REG_STAT, 32'h0);
    cmp({9'h0, TWI_ADDR, st, 8'h00}, rd & 32'h007F_FF01);
    cmp(32'h0, {31'h0, busy_out});
    cmp(32'd24, {26'h0, fnb[0]});
    cmp({8'h00, CMD_MEASURE, CMD_ARG, CMD_ARG}, fmo[0] & 32'h00FF_FFFF);
    cmp(32'd32, {26'h0, fnb[$]});
    cmp({CMD_NOP, CMD_ARG, CMD_ARG, CMD_ARG}, fmo[$]);
    cmp({st, p}, fmi[$]);
    if (mode == WAIT_POLL)
    begin
      cmp({26'h0, 6'd8}, {26'h0, fnb[1]});
      cmp({24'h0, CMD_NOP}, fmo[1] & 32'h0000_00FF);
      cmp(32'h1, {31'h0, fmi[1][ST_BUSY]});
      cmp({24'h0, st}, fmi[fmi.size() - 2] & 32'h0000_00FF);
    end
    else
      cmp(32'd2, fnb.size());
  endtask

  initial
  begin
    rst_b = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    pressure = 24'h00_0000;
    sat = 1'b0;
    mfail = 1'b0;
    sclk_p = 1'b0;
    nb = 6'h00;
    miscompares = 0;
    checks_done = 0;
    reset();
    acc(1'b0, REG_STAT, 32'h0);
    cmp({9'h0, TWI_ADDR, 16'h0000}, rd & 32'h007F_0001);
    acc(1'b0, 5'h14, 32'h0);
    cmp(32'h0, rd);
    acc(1'b0, REG_IRQ, 32'h0);
    cmp(32'h0, rd);
    run(WAIT_POLL, 24'hA5_5A3C, 1'b0, 2'h3);
    run(WAIT_DELAY, 24'h00_0001, 1'b1, 2'h1);
    run(2'h2, 24'hFF_FFFF, 1'b0, 2'h0);
    mfail <= 1'b1;
    reset();
    run(2'h3, 24'h80_0000, 1'b1, 2'h2);
    run(WAIT_POLL, 24'h12_3456, 1'b0, 2'h1);
    summarize();
  end
endmodule
`default_nettype wire

// ===== dv/pssr_properties.sv
`timescale 1ns/1ns
`default_nettype none
module pssr_properties #(
  parameter int CONV = 100
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ss_n,
  input wire logic miso,
  input wire logic eoc
);
  logic sclk_q;
  logic [7:0] hi_q;
  logic [7:0] lo_q;
  logic [7:0] gap_q;
  logic [5:0] bits_q;
  logic [19:0] eoc_lo_q;

  // Phase widths, frame gap, bit count and conversion length
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclk_q <= 1'b0;
      hi_q <= 8'h00;
      lo_q <= 8'h00;
      gap_q <= 8'hFF;
      bits_q <= 6'h00;
      eoc_lo_q <= 20'h0_0000;
    end
    else
    begin
      sclk_q <= sclk;
      hi_q <= sclk ? hi_q + 8'h01 : 8'h00;
      lo_q <= (!sclk && !ss_n) ? lo_q + 8'h01 : 8'h00;
      gap_q <= !ss_n ? 8'h00 : ((gap_q == 8'hFF) ? gap_q : gap_q + 8'h01);
      bits_q <= ss_n ? 6'h00 : bits_q + {5'h00, sclk & !sclk_q};
      eoc_lo_q <= eoc ? 20'h0_0000 : eoc_lo_q + 20'h0_0001;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_last_fall;
    $past(sclk, 3) && !$past(sclk, 2) && !$past(sclk);
  endsequence

  sequence s_lead_done;
    !ss_n && (lo_q == 8'd50 || lo_q == 8'd20);
  endsequence

  chk_idle_low: assert property (ss_n |-> !sclk)
    else $error("serial clock not low while deselected");
  chk_mosi_phase: assert property ($changed(mosi) |-> !sclk)
    else $error("host data changed while clock high");
  chk_miso_phase: assert property ($changed(miso) |-> !sclk)
    else $error("sensor data changed while clock high");
  chk_select_lead: assert property ($rose(sclk) |-> s_lead_done)
    else $error("wrong low time before a clock rise");
  chk_high_width: assert property ($fell(sclk) |-> hi_q == 8'd20)
    else $error("clock high phase not 20 cycles");
  chk_frame_end: assert property ($rose(ss_n) |-> !sclk ##0 s_last_fall)
    else $error("select released without clock stopped two cycles");
  chk_frame_gap: assert property ($fell(ss_n) |-> gap_q >= 8'd40)
    else $error("select idle time too short");
  chk_frame_bits: assert property ($rose(ss_n) |-> bits_q inside {6'd8, 6'd24, 6'd32})
    else $error("frame holds a count of bits other than 8, 24 or 32");
  chk_conv_len: assert property ($rose(eoc) |-> eoc_lo_q >= CONV)
    else $error("conversion ended too early");
  cov_fetch: cover property ($rose(ss_n) && bits_q == 6'd32);
endmodule
`default_nettype wire

// ===== shared/pssr_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pssr_if;
  logic sclk;
  logic mosi;
  logic ss_n;
  logic miso;
  logic eoc;
  modport sensor (input sclk, input mosi, input ss_n, output miso, output eoc);
  modport host (output sclk, output mosi, output ss_n, input miso, input eoc);
endinterface
`default_nettype wire

// ===== shared/pssr_pkg.sv
`default_nettype none
package pssr_pkg;
  localparam logic [7:0] CMD_MEASURE = 8'hAA;
  localparam logic [7:0] CMD_ARG = 8'h00;
  localparam logic [7:0] CMD_NOP = 8'hF0;
  localparam logic [6:0] TWI_ADDR = 7'h18;
  localparam int ST_POWER = 6;
  localparam int ST_BUSY = 5;
  localparam int ST_MEMF = 2;
  localparam int ST_SAT = 0;
  localparam logic [1:0] MEAS_BYTES = 2'h3;
  localparam logic [1:0] CMD_LAST = 2'h2;
  localparam logic [1:0] POLL_LAST = 2'h0;
  localparam logic [1:0] FETCH_LAST = 2'h3;
  localparam logic [1:0] STEP_CMD = 2'h0;
  localparam logic [1:0] STEP_POLL = 2'h1;
  localparam logic [1:0] STEP_FETCH = 2'h2;
  localparam logic [1:0] WAIT_POLL = 2'h0;
  localparam logic [1:0] WAIT_DELAY = 2'h1;
  localparam int SYS_MHZ = 20;
  localparam int T_HDSS_NS = 2500;
  localparam int T_SUSS_NS = 100;
  localparam int T_BUS_NS = 2000;
  localparam int T_HALF_NS = 1000;
  localparam int T_WAIT_US = 5000;
  localparam int T_CONV_US = 4000;
  localparam int HDSS_CYC = (T_HDSS_NS * SYS_MHZ + 999) / 1000;
  localparam int SUSS_CYC = (T_SUSS_NS * SYS_MHZ + 999) / 1000;
  localparam int BUS_CYC = (T_BUS_NS * SYS_MHZ + 999) / 1000;
  localparam int HALF_CYC = (T_HALF_NS * SYS_MHZ + 999) / 1000;
  localparam int WAIT_CYC = T_WAIT_US * SYS_MHZ;
  localparam int CONV_CYC = T_CONV_US * SYS_MHZ;
  localparam int AW = 5;
  localparam int DW = 32;
  localparam logic [AW-1:0] REG_CTRL = 5'h00;
  localparam logic [AW-1:0] REG_STAT = 5'h04;
  localparam logic [AW-1:0] REG_DATA = 5'h08;
  localparam logic [AW-1:0] REG_IRQ = 5'h0C;
  localparam logic [AW-1:0] REG_MASK = 5'h10;
  localparam int CTRL_GO = 0;
  localparam int CTRL_MODE = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_BYTE = 8;
  localparam int STAT_ADDR = 16;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  typedef enum logic [1:0] {
    D_STANDBY = 2'h1,
    D_CONVERT = 2'h2
  } pssr_dev_st_t;
  typedef enum logic [6:0] {
    H_IDLE = 7'h01,
    H_LEAD = 7'h02,
    H_LOW = 7'h04,
    H_HIGH = 7'h08,
    H_TRAIL = 7'h10,
    H_GAP = 7'h20,
    H_WAIT = 7'h40
  } pssr_host_st_t;
endpackage
`default_nettype wire
